// file: hw/pkt_dma.sv
// Packet transmit and receive initiator controllers with APB registers
// Assumes APB master on i_core_clk; link clock and bus answers are async
//
// What this block does
// - Non-zero packet size write makes a restart; zero write does not.
// - Size written while disabled restarts once enable goes high.
// - Non-continuous mode starts every packet at the stored base pointer.
// - Continuous mode starts each packet where the previous one ended.
// - Continuous restart clears byte progress and counts a finished packet.
// - Dropping enable clears the finished-packet counter.
// - Restart is blocked while enable is low.
// - Controller reset clears counters and reloads the base pointer.
// - Transmit uses memory write, receive uses memory read.
// - Remainder below a full burst goes as single beats.
// - Byte enables all active, or 1100 in 16-bit word mode.
// - Alarm plus granularity reaching 128 bytes drops DMA request.
// - Bus-error status and enable are one copy seen in both groups.
// - PCI interrupt lines are never driven.
// - Three interrupt outputs, each maskable per condition.
// - Initiator path interrupts on retry, target and master abort.
// - Each controller interrupts on FIFO error and normal completion.
// - System clock always faster than PCI clock, 2x or 4x; the bench runs it at 8x.
// - Wait for FIFO data or room for a full burst.
// - Address increments per burst unless increment is disabled.
// - Low two length bits ignored; maximum packet is 65532 bytes.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "pkt_dma_regs.svh"

module pkt_dma (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_pci_clk,
  input wire logic [1:0] i_fifo_lvl_ok,
  input wire logic [1:0] i_fifo_err,
  input wire logic [1:0] i_bus_done,
  input wire logic [2:0] i_init_err,
  input wire logic [7:0] i_tx_fifo_bytes,
  input wire logic [7:0] i_rx_fifo_bytes,
  output pkt_dma_pkg::pci_req_s o_tx_req,
  output pkt_dma_pkg::pci_req_s o_rx_req,
  output logic [1:0] o_dma_req,
  output logic [1:0] o_fifo_reset,
  output logic [3:0] o_pci_int_oe,
  output logic [2:0] o_irq
);

  // ==========================================================
  // Helpers
  // ==========================================================
  // Byte enables for a data phase
  function automatic logic [3:0] be_of(input logic word16);
    be_of = word16 ? `BE_WORD16 : `BE_ALL;
  endfunction

  // Burst length for the bytes that remain
  function automatic logic [3:0] beats_of(input logic [15:0] left,
                                          input logic [3:0] lim);
    logic [17:0] full;
    full = {12'h000, lim, 2'b00};
    beats_of = ({2'b00, left} >= full) ? lim : 4'h1;
  endfunction

  // ==========================================================
  // Synchronisers for link-side inputs
  // ==========================================================
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic pclk_last_q;
  logic pclk_rise;
  // Two flops on pci clock, done, fifo level flags and fifo errors
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
    end else begin
      s1_q <= {i_pci_clk, i_bus_done, i_fifo_lvl_ok, i_fifo_err, 1'b0};
      s2_q <= s1_q;
    end
  end
  // Link clock edge finder
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pclk_last_q <= 1'b0;
    end else begin
      pclk_last_q <= s2_q[7];
    end
  end
  assign pclk_rise = s2_q[7] & ~pclk_last_q;
  logic [2:0] ie1_q;
  logic [2:0] ie2_q;
  // Initiator error lines
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ie1_q <= 3'h0;
      ie2_q <= 3'h0;
    end else begin
      ie1_q <= i_init_err;
      ie2_q <= ie1_q;
    end
  end

  // ==========================================================
  // APB register file
  // ==========================================================
  logic [31:0] start_q [2];
  logic [15:0] size_q [2];
  logic [31:0] ctrl_q [2];
  logic [15:0] fctl_q [2];
  logic [2:0] irqen_q [2];
  logic [1:0] stat_q [2];
  logic bus_err_q;
  logic bus_err_en_q;
  logic [2:0] istat_q;
  logic [2:0] ien_q;
  logic [1:0] pend_q;
  logic [31:0] addr_q [2];
  logic [15:0] left_q [2];
  logic [15:0] bdone_q [2];
  logic [15:0] pdone_q [2];
  pkt_dma_pkg::ctl_state_e st_q [2];
  logic wr;
  logic ch;
  logic [7:0] ofs;
  logic [1:0] size_wr;
  logic [1:0] restart;

  assign wr = i_psel & i_penable & i_pwrite;
  assign ch = i_paddr[6];
  assign ofs = i_paddr & 8'h3F;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;

  // Control writes per controller
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 2; i++) begin
        start_q[i] <= 32'h0000_0000;
        size_q[i] <= 16'h0000;
        ctrl_q[i] <= `CTRL_RST_VAL;
        fctl_q[i] <= 16'h0000;
        irqen_q[i] <= 3'h0;
      end
      bus_err_en_q <= 1'b0;
      ien_q <= 3'h0;
    end else if (wr) begin
      if (ofs == `OFS_START_ADDR) begin
        start_q[ch] <= i_pwdata;
      end else if (ofs == `OFS_PKT_SIZE) begin
        size_q[ch] <= {i_pwdata[15:2], 2'b00};
      end else if (ofs == `OFS_CTRL) begin
        ctrl_q[ch] <= i_pwdata;
      end else if (ofs == `OFS_FIFO_CTRL) begin
        fctl_q[ch] <= i_pwdata[15:0];
      end else if (ofs == `OFS_IRQ_EN) begin
        irqen_q[ch] <= i_pwdata[2:0];
        bus_err_en_q <= i_pwdata[`ST_BUS_ERR];
      end else if (ofs == `OFS_INIT_EN) begin
        ien_q <= i_pwdata[2:0];
      end
    end
  end

  // Packet size write strobe per controller
  always_comb begin
    size_wr = 2'b00;
    if (wr && ofs == `OFS_PKT_SIZE && i_pwdata[15:2] != 14'h0) begin
      size_wr[ch] = 1'b1;
    end
  end

  // Read mux
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      if (ofs == `OFS_START_ADDR) begin
        o_prdata <= start_q[ch];
      end else if (ofs == `OFS_PKT_SIZE) begin
        o_prdata <= {16'h0000, size_q[ch]};
      end else if (ofs == `OFS_CTRL) begin
        o_prdata <= ctrl_q[ch];
      end else if (ofs == `OFS_FIFO_CTRL) begin
        o_prdata <= {16'h0000, fctl_q[ch]};
      end else if (ofs == `OFS_STATUS) begin
        o_prdata <= {29'h0, bus_err_q, stat_q[ch]};
      end else if (ofs == `OFS_IRQ_EN) begin
        o_prdata <= {29'h0, bus_err_en_q, irqen_q[ch][1:0]};
      end else if (ofs == `OFS_PROGRESS) begin
        o_prdata <= {pdone_q[ch], bdone_q[ch]};
      end else if (ofs == `OFS_INIT_STAT) begin
        o_prdata <= {29'h0, istat_q};
      end else if (ofs == `OFS_INIT_EN) begin
        o_prdata <= {29'h0, ien_q};
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Restart sequencing
  // ==========================================================
  // Held size write waiting for enable
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ctrl_q[i][`CTRL_RESET]) begin
          pend_q[i] <= 1'b0;
        end else if (size_wr[i] || restart[i]) begin
          pend_q[i] <= size_wr[i] & ~ctrl_q[i][`CTRL_ENABLE];
        end
      end
    end
  end
  // One-cycle restart, blocked while disabled or in reset
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      restart[i] = ctrl_q[i][`CTRL_ENABLE] & ~ctrl_q[i][`CTRL_RESET]
                   & (pend_q[i] | size_wr[i]);
    end
  end

  // ==========================================================
  // Packet controllers
  // ==========================================================
  logic [1:0] done_ev;
  logic [1:0] ferr_ev;
  logic [1:0] room;
  assign room[0] = s2_q[3];
  assign room[1] = s2_q[4];
  // Beats for the next transaction of controller i
  function automatic logic [3:0] cur_beats(input int i);
    cur_beats = beats_of(left_q[i], ctrl_q[i][`CTRL_BEATS_LO +: 4]);
  endfunction
  // Address, counters and state per controller
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 2; i++) begin
        st_q[i] <= pkt_dma_pkg::ST_IDLE;
        addr_q[i] <= 32'h0000_0000;
        left_q[i] <= 16'h0000;
        bdone_q[i] <= 16'h0000;
        pdone_q[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ctrl_q[i][`CTRL_RESET]) begin
          st_q[i] <= pkt_dma_pkg::ST_IDLE;
          addr_q[i] <= start_q[i];
          bdone_q[i] <= 16'h0000;
          pdone_q[i] <= 16'h0000;
        end else begin
          if (!ctrl_q[i][`CTRL_ENABLE]) begin
            pdone_q[i] <= 16'h0000;
          end
          case (st_q[i])
            pkt_dma_pkg::ST_IDLE, pkt_dma_pkg::ST_DONE: begin
              if (restart[i]) begin
                st_q[i] <= pkt_dma_pkg::ST_WAIT;
                left_q[i] <= size_wr[i] ? {i_pwdata[15:2], 2'b00}
                  : size_q[i];
                bdone_q[i] <= 16'h0000;
                if (!ctrl_q[i][`CTRL_CONT]) begin
                  addr_q[i] <= start_q[i];
                end else if (st_q[i] == pkt_dma_pkg::ST_DONE) begin
                  pdone_q[i] <= pdone_q[i] + 16'h0001;
                end
              end
            end
            pkt_dma_pkg::ST_WAIT: begin
              // Old done must drain before the next burst
              if (room[i] && pclk_rise && !s2_q[5 + i]) begin
                st_q[i] <= pkt_dma_pkg::ST_BURST;
              end
            end
            pkt_dma_pkg::ST_BURST: begin
              if (s2_q[5 + i]) begin
                left_q[i] <= left_q[i] - {10'h0, cur_beats(i), 2'b00};
                bdone_q[i] <= bdone_q[i] + {10'h0, cur_beats(i), 2'b00};
                if (!ctrl_q[i][`CTRL_NOINC]) begin
                  addr_q[i] <= addr_q[i]
                    + {26'h0, cur_beats(i), 2'b00};
                end
                st_q[i] <= (left_q[i] == {10'h0, cur_beats(i), 2'b00})
                  ? pkt_dma_pkg::ST_DONE : pkt_dma_pkg::ST_WAIT;
              end
            end
            default: st_q[i] <= pkt_dma_pkg::ST_IDLE;
          endcase
        end
      end
    end
  end

  // Completion and FIFO error events
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      done_ev[i] = (st_q[i] == pkt_dma_pkg::ST_BURST) & s2_q[5 + i]
        & (left_q[i] == {10'h0, cur_beats(i), 2'b00});
    end
    ferr_ev = s2_q[2:1];
  end

  // Transaction requests to the bus engine
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_req <= '0;
      o_rx_req <= '0;
    end else begin
      o_tx_req.valid <= (st_q[0] == pkt_dma_pkg::ST_BURST);
      o_tx_req.cmd <= `CMD_MEM_WRITE;
      o_tx_req.addr <= addr_q[0];
      o_tx_req.beats <= cur_beats(0);
      o_tx_req.be_n <= be_of(ctrl_q[0][`CTRL_WORD16]);
      o_rx_req.valid <= (st_q[1] == pkt_dma_pkg::ST_BURST);
      o_rx_req.cmd <= `CMD_MEM_READ;
      o_rx_req.addr <= addr_q[1];
      o_rx_req.beats <= cur_beats(1);
      o_rx_req.be_n <= be_of(ctrl_q[1][`CTRL_WORD16]);
    end
  end

  // ==========================================================
  // DMA request from FIFO alarm
  // ==========================================================
  logic [8:0] thr [2];
  always_comb begin
    thr[0] = {1'b0, fctl_q[0][7:0]} + {1'b0, fctl_q[0][15:8]};
    thr[1] = {1'b0, fctl_q[1][7:0]} + {1'b0, fctl_q[1][15:8]};
  end
  // Tx asks while data below alarm, rx while data at or above it
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dma_req <= 2'b00;
      o_fifo_reset <= 2'b00;
    end else begin
      o_dma_req[0] <= (thr[0] < {1'b0, `FIFO_BYTES})
        & (i_tx_fifo_bytes < fctl_q[0][7:0]);
      o_dma_req[1] <= (thr[1] < {1'b0, `FIFO_BYTES})
        & (i_rx_fifo_bytes >= fctl_q[1][7:0]);
      o_fifo_reset[0] <= ctrl_q[0][`CTRL_FIFO_RST];
      o_fifo_reset[1] <= ctrl_q[1][`CTRL_FIFO_RST];
    end
  end

  // ==========================================================
  // Status flags, set wins over write-one clear
  // ==========================================================
  logic [2:0] iclr;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stat_q[0] <= 2'b00;
      stat_q[1] <= 2'b00;
      bus_err_q <= 1'b0;
      istat_q <= 3'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        stat_q[i] <= (stat_q[i] & ~((wr && ofs == `OFS_STATUS && ch == i)
          ? i_pwdata[1:0] : 2'b00)) | {done_ev[i], ferr_ev[i]};
      end
      bus_err_q <= (bus_err_q & ~(wr && ofs == `OFS_STATUS
        && i_pwdata[`ST_BUS_ERR])) | (|ie2_q);
      istat_q <= (istat_q & ~iclr) | ie2_q;
    end
  end
  assign iclr = (wr && ofs == `OFS_INIT_STAT) ? i_pwdata[2:0] : 3'h0;

  // Interrupt outputs: initiator, tx, rx
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 3'h0;
    end else begin
      o_irq[0] <= |(istat_q & ien_q);
      o_irq[1] <= |(stat_q[0] & irqen_q[0][1:0])
        | (bus_err_q & bus_err_en_q);
      o_irq[2] <= |(stat_q[1] & irqen_q[1][1:0]) | (bus_err_q & bus_err_en_q);
    end
  end
  assign o_pci_int_oe = 4'h0;

  // ==========================================================
  // Checks
  // ==========================================================
  property p_restart_len;
    @(posedge i_core_clk) disable iff (!i_rstn)
      restart[0] |=> !restart[0];
  endproperty
  a_restart_len: assert property (p_restart_len)
    else $error("restart wider than one cycle");
  property p_no_restart_dis;
    @(posedge i_core_clk) disable iff (!i_rstn)
      !ctrl_q[0][`CTRL_ENABLE] |-> !restart[0];
  endproperty
  a_no_restart_dis: assert property (p_no_restart_dis)
    else $error("restart while disabled");
  property p_size_restart;
    @(posedge i_core_clk) disable iff (!i_rstn)
      size_wr[0] && ctrl_q[0][`CTRL_ENABLE] && !ctrl_q[0][`CTRL_RESET]
      |-> restart[0];
  endproperty
  a_size_restart: assert property (p_size_restart)
    else $error("size write gave no restart");
  property p_pend;
    @(posedge i_core_clk) disable iff (!i_rstn)
      pend_q[0] && $rose(ctrl_q[0][`CTRL_ENABLE]) && !ctrl_q[0][`CTRL_RESET]
      |-> restart[0];
  endproperty
  a_pend: assert property (p_pend)
    else $error("held restart lost");
  property p_reload;
    @(posedge i_core_clk) disable iff (!i_rstn)
      ctrl_q[0][`CTRL_RESET] |=> addr_q[0] == $past(start_q[0])
        && pdone_q[0] == 16'h0000;
  endproperty
  a_reload: assert property (p_reload)
    else $error("reset did not reload");
  property p_tx_cmd;
    @(posedge i_core_clk) disable iff (!i_rstn)
      o_tx_req.valid |-> o_tx_req.cmd == `CMD_MEM_WRITE
        && o_rx_req.cmd == `CMD_MEM_READ;
  endproperty
  a_tx_cmd: assert property (p_tx_cmd)
    else $error("wrong pci command");
  property p_be;
    @(posedge i_core_clk) disable iff (!i_rstn)
      o_tx_req.valid && $past(ctrl_q[0][`CTRL_WORD16])
      |-> o_tx_req.be_n == `BE_WORD16;
  endproperty
  a_be: assert property (p_be)
    else $error("byte enables wrong");
  property p_nonc_start;
    @(posedge i_core_clk) disable iff (!i_rstn)
      restart[0] && !ctrl_q[0][`CTRL_CONT]
      && st_q[0] != pkt_dma_pkg::ST_WAIT && st_q[0] != pkt_dma_pkg::ST_BURST
      |=> addr_q[0] == $past(start_q[0]);
  endproperty
  a_nonc_start: assert property (p_nonc_start)
    else $error("packet not at base pointer");
  property p_noint;
    @(posedge i_core_clk) disable iff (!i_rstn) o_pci_int_oe == 4'h0;
  endproperty
  a_noint: assert property (p_noint)
    else $error("pci interrupt driven");

endmodule

// file: hw/pkt_dma_regs.svh
// Register offsets, field positions, reset values, command codes and byte enables
// Assumes inclusion by bare name from design files
`ifndef PKT_DMA_REGS_SVH
`define PKT_DMA_REGS_SVH
// Register byte offsets, per controller: tx at 0x00, rx at 0x40
`define OFS_START_ADDR 8'h00
`define OFS_PKT_SIZE 8'h04
`define OFS_CTRL 8'h08
`define OFS_FIFO_CTRL 8'h0C
`define OFS_STATUS 8'h10
`define OFS_IRQ_EN 8'h14
`define OFS_PROGRESS 8'h18
`define OFS_INIT_STAT 8'h30
`define OFS_INIT_EN 8'h34
`define RX_BASE 8'h40
// Control register fields
`define CTRL_CMD_LO 0
`define CTRL_BEATS_LO 4
`define CTRL_RETRY_LO 8
`define CTRL_CONT 16
`define CTRL_NOINC 17
`define CTRL_WORD16 18
`define CTRL_ENABLE 19
`define CTRL_RESET 20
`define CTRL_FIFO_RST 21
`define CTRL_RST_VAL 32'h0010_0000
// FIFO control fields
`define FC_ALARM_LO 0
`define FC_GRAN_LO 8
`define FIFO_BYTES 8'h80
// Status bits: fifo error, normal done, bus error (shared)
`define ST_FIFO_ERR 0
`define ST_DONE 1
`define ST_BUS_ERR 2
// Initiator status bits: retry, target abort, master abort
`define IS_RETRY 0
`define IS_TABORT 1
`define IS_MABORT 2
// PCI commands and byte enables
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define BE_ALL 4'h0
`define BE_WORD16 4'hC
`define MAX_PKT 16'hFFFC
`endif

// file: hw/pkt_dma_pkg.sv
// Types shared by the packet initiator
// Assumes the register header supplies constants
package pkt_dma_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_BURST = 2'b10,
    ST_DONE = 2'b11
  } ctl_state_e;
  // One PCI transaction request toward the bus engine
  typedef struct packed {
    logic valid;
    logic [3:0] cmd;
    logic [31:0] addr;
    logic [3:0] beats;
    logic [3:0] be_n;
  } pci_req_s;
  // Bus engine answer
  typedef struct packed {
    logic done;
    logic retry_err;
    logic tabort;
    logic mabort;
  } pci_rsp_s;
endpackage

// file: tb/pci_far_model.sv
// Far side model: PCI targets completing transactions, DMA-fed FIFOs
// Assumes requests from the block are registered on the same clock
`timescale 1ns/1ps

module pci_far_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire pkt_dma_pkg::pci_req_s i_tx_req,
  input wire pkt_dma_pkg::pci_req_s i_rx_req,
  input wire logic i_slow,
  output logic [1:0] o_bus_done,
  output logic [1:0] o_lvl_ok,
  output logic [7:0] o_tx_bytes,
  output logic [7:0] o_rx_bytes
);
  // ==========================================================
  // Target answer and FIFO level
  logic [3:0] cnt [2];
  logic [4:0] stall_q;
  logic [1:0] vld;

  assign vld = {i_rx_req.valid, i_tx_req.valid};
  // Fill level follows the level flag, so both views agree
  assign o_tx_bytes = o_lvl_ok[0] ? 8'h20 : 8'h04;
  assign o_rx_bytes = o_lvl_ok[1] ? 8'h04 : 8'h7C;

  // Done held until the request drops; slow mode waits longer
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bus_done <= 2'b00;
      cnt[0] <= 4'h1;
      cnt[1] <= 4'h1;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (vld[i] && !o_bus_done[i]) begin
          if (cnt[i] == 4'h0) begin
            o_bus_done[i] <= 1'b1;
            cnt[i] <= i_slow ? 4'h9 : 4'h1;
          end else begin
            cnt[i] <= cnt[i] - 4'h1;
          end
        end else if (!vld[i]) begin
          o_bus_done[i] <= 1'b0;
        end
      end
    end
  end

  // FIFO data or room comes and goes while stalling
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stall_q <= 5'h00;
      o_lvl_ok <= 2'b00;
    end else begin
      stall_q <= stall_q + 5'h01;
      o_lvl_ok <= i_slow ? {2{stall_q[4]}} : 2'b11;
    end
  end
endmodule

// file: tb/tb.sv
// Self-checking bench for the packet initiator controllers
// Assumes the far side model and the register header are compiled
`timescale 1ns/1ps
`include "pkt_dma_regs.svh"

module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pci_clk = 1'b0;
  logic slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r, a;
  logic pready, pslverr, ni, w16;
  logic [1:0] ferr = 2'b00, lvl_ok, done, dma_req, fifo_rst;
  logic [1:0] prev = 2'b00;
  logic [2:0] ierr = 3'b000, irq;
  logic [7:0] txb, rxb;
  logic [3:0] int_oe;
  pkt_dma_pkg::pci_req_s txr, rxr, e;
  pkt_dma_pkg::pci_req_s exp_q[$];
  int n_errors = 0, total_checks = 0, c, bt, w;

  always #10 clk = ~clk;
  always #80 pci_clk = ~pci_clk;

  pkt_dma dut (.i_core_clk(clk), .i_rstn(rstn), .i_paddr(paddr),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_pci_clk(pci_clk), .i_fifo_lvl_ok(lvl_ok),
    .i_fifo_err(ferr), .i_bus_done(done), .i_init_err(ierr),
    .i_tx_fifo_bytes(txb), .i_rx_fifo_bytes(rxb), .o_tx_req(txr),
    .o_rx_req(rxr), .o_dma_req(dma_req), .o_fifo_reset(fifo_rst),
    .o_pci_int_oe(int_oe), .o_irq(irq));

  pci_far_model far (.i_clk(clk), .i_rstn(rstn), .i_tx_req(txr),
    .i_rx_req(rxr), .i_slow(slow), .o_bus_done(done),
    .o_lvl_ok(lvl_ok), .o_tx_bytes(txb), .o_rx_bytes(rxb));

  // ==========================================================
  // Reporting
  task test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input string nm, input logic [63:0] x, input logic [63:0] g);
    total_checks++;
    if (g !== x) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, x, g);
    end
  endtask

  // ==========================================================
  // APB master, held until pready is seen
  task apb(input logic [7:0] ad, input logic wr_en, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= ad;
    pwrite <= wr_en;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      test_done;
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input int ch, input logic [7:0] ofs, input logic [31:0] d);
    apb((ch != 0 ? `RX_BASE : 8'h00) + ofs, 1'b1, d);
  endtask

  task rd(input int ch, input logic [7:0] ofs);
    apb((ch != 0 ? `RX_BASE : 8'h00) + ofs, 1'b0, 32'h0000_0000);
  endtask

  // ==========================================================
  // Expected transactions of one packet; returns the next address
  function automatic logic [31:0] plan(input int ch, input logic [31:0] ad,
      input int b, input int by, input logic noinc, input logic wd);
    int rem, n;
    pkt_dma_pkg::pci_req_s q;
    rem = by & ~3;
    while (rem > 0) begin
      n = (rem >= b * 4) ? b : 1;
      q.valid = 1'b1;
      q.cmd = ch != 0 ? `CMD_MEM_READ : `CMD_MEM_WRITE;
      q.addr = ad;
      q.beats = 4'(n);
      q.be_n = wd ? `BE_WORD16 : `BE_ALL;
      exp_q.push_back(q);
      rem -= n * 4;
      if (!noinc) ad += 32'(n * 4);
    end
    return ad;
  endfunction

  function automatic logic [31:0] ctl(input int b, input logic noinc,
      input logic wd, input logic en, input logic cn, input logic rs);
    ctl = 32'h0000_0000;
    ctl[7:4] = 4'(b);
    ctl[15:8] = 8'($urandom);
    ctl[`CTRL_CONT] = cn;
    ctl[`CTRL_NOINC] = noinc;
    ctl[`CTRL_WORD16] = wd;
    ctl[`CTRL_ENABLE] = en;
    ctl[`CTRL_RESET] = rs;
  endfunction

  task wait_done(input int ch);
    int n;
    n = 0;
    r = 32'h0000_0000;
    while (r[`ST_DONE] !== 1'b1 && n < 1000) begin
      rd(ch, `OFS_STATUS);
      n++;
    end
    chk("done", 1, r[`ST_DONE]);
    if (n >= 1000) test_done;
    chk("left", 0, exp_q.size());
    chk("irq_done", 1, irq[ch+1]);
    wr(ch, `OFS_STATUS, 32'h0000_0002);
    rd(ch, `OFS_STATUS);
    chk("done_clr", 0, r[`ST_DONE]);
    chk("irq_clr", 0, irq[ch+1]);
  endtask

  // ==========================================================
  // Request monitor against the expected queue
  always @(posedge clk) begin
    for (int k = 0; k < 2; k++) begin
      e = k != 0 ? rxr : txr;
      if (e.valid === 1'b1 && !prev[k]) begin
        if (exp_q.size() == 0)
          chk("unexpected_req", 0, 1);
        else
          chk("req", exp_q.pop_front(), e);
      end
      prev[k] = (e.valid === 1'b1);
    end
  end

  initial begin
    #1_800_000;
    n_errors++;
    test_done;
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hf0248717));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (c = 0; c < 2; c++) begin
      rd(c, `OFS_CTRL);
      chk("ctrl_rst", `CTRL_RST_VAL, r);
    end
    rd(0, 8'h20);
    chk("unmapped", 0, r);
    wr(0, `OFS_IRQ_EN, 32'h0000_0007);
    rd(1, `OFS_IRQ_EN);
    chk("en_shared", 1, r[2]);
    wr(1, `OFS_IRQ_EN, 32'h0000_0003);
    rd(0, `OFS_IRQ_EN);
    chk("en_shared2", 3, r);
    wr(0, `OFS_INIT_EN, 32'h0000_0007);
    // Initiator errors, then FIFO errors, each raised and cleared
    for (c = 0; c < 5; c++) begin
      if (c < 3) ierr <= 3'(1 << c);
      else ferr <= 2'(1 << (c - 3));
      repeat (3) @(posedge clk);
      ierr <= 3'b000;
      ferr <= 2'b00;
      repeat (4) @(posedge clk);
      chk("irq_err", 1, irq[c < 3 ? 0 : c - 2]);
      rd(c - 3, c < 3 ? `OFS_INIT_STAT : `OFS_STATUS);
      chk("err_stat", 1, r[c < 3 ? c : 0]);
      wr(c - 3, c < 3 ? `OFS_INIT_STAT : `OFS_STATUS,
        c < 3 ? 32'(1 << c) : 32'h0000_0001);
      rd(0, `OFS_STATUS);
      a = r;
      rd(1, `OFS_STATUS);
      chk("berr_shared", a[2], r[2]);
      chk("irq_err_clr", 0, irq[c < 3 ? 0 : c - 2]);
    end
    wr(1, `OFS_STATUS, 32'h0000_0004);
    rd(0, `OFS_STATUS);
    chk("berr_clr", 0, r[2]);
    for (c = 0; c < 2; c++) begin
      wr(c, `OFS_CTRL, 32'h0030_0000);
      repeat (2) @(posedge clk);
      chk("fifo_rst", 1, fifo_rst[c]);
      wr(c, `OFS_FIFO_CTRL, c ? 32'h0000_0804 : 32'h0000_0840);
      repeat (2) @(posedge clk);
      chk("dma_req", 1, dma_req[c]);
      wr(c, `OFS_FIFO_CTRL, c ? 32'h0000_7C04 : 32'h0000_4040);
      repeat (2) @(posedge clk);
      chk("dma_drop", 0, dma_req[c]);
      wr(c, `OFS_FIFO_CTRL, 32'h0000_0820);
    end
    // Random packets with corner cases first
    for (int k = 0; k < 6; k++) begin
      c = k < 3 ? k % 2 : $urandom % 2;
      bt = k == 0 ? 8 : (k == 1 ? 1 : 1 + $urandom % 8);
      w = k == 0 ? 20 : 1 + $urandom % 20;
      ni = k == 3 || (k > 3 && $urandom % 2);
      w16 = k == 2 || (k > 3 && $urandom % 2);
      slow <= k > 2;
      a = $urandom & 32'hFFFF_FFFC;
      void'(plan(c, a, bt, w * 4, ni, w16));
      wr(c, `OFS_START_ADDR, a);
      wr(c, `OFS_CTRL, ctl(bt, ni, w16, 1, 0, 0));
      wr(c, `OFS_PKT_SIZE, 32'(w * 4 + $urandom % 4));
      wait_done(c);
    end
    void'(plan(c, a, bt, w * 4, ni, w16));
    wr(c, `OFS_PKT_SIZE, 32'(w * 4));
    wait_done(c);
    wr(c, `OFS_PKT_SIZE, 32'h0000_0000);
    wr(c, `OFS_CTRL, ctl(bt, ni, w16, 0, 0, 0));
    wr(c, `OFS_PKT_SIZE, 32'(w * 4));
    repeat (40) @(posedge clk);
    void'(plan(c, a, bt, w * 4, ni, w16));
    wr(c, `OFS_CTRL, ctl(bt, ni, w16, 1, 0, 0));
    wait_done(c);
    // Continuous mode on transmit
    a = $urandom & 32'hFFFF_FFFC;
    wr(0, `OFS_CTRL, ctl(2, 0, 0, 1, 1, 1));
    wr(0, `OFS_PKT_SIZE, 32'h0000_0008);
    wr(0, `OFS_START_ADDR, a);
    wr(0, `OFS_CTRL, ctl(2, 0, 0, 1, 1, 0));
    for (int k = 0; k < 2; k++) begin
      a = plan(0, a, 2, 8, 0, 0);
      wr(0, `OFS_PKT_SIZE, 32'h0000_0008);
      wait_done(0);
    end
    rd(0, `OFS_PROGRESS);
    chk("packets", 1, r[31:16]);
    chk("bytes", 8, r[15:0]);
    wr(0, `OFS_CTRL, ctl(2, 0, 0, 0, 1, 0));
    rd(0, `OFS_PROGRESS);
    chk("packets_clr", 0, r[31:16]);
    wr(0, `OFS_CTRL, ctl(2, 0, 0, 1, 1, 1));
    a = $urandom & 32'hFFFF_FFFC;
    wr(0, `OFS_START_ADDR, a);
    wr(0, `OFS_CTRL, ctl(2, 0, 0, 1, 1, 0));
    void'(plan(0, a, 2, 8, 0, 0));
    wr(0, `OFS_PKT_SIZE, 32'h0000_0008);
    wait_done(0);
    chk("int_oe", 0, int_oe);
    chk("slverr", 0, pslverr);
    test_done;
  end
endmodule
